// *** design/led_map_pkg.sv ***
package led_map_pkg;

  // Bus geometry
  localparam int ADDR_W = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_INSTR = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PROG_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PROG_DATA = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_GEN_OUT = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_VAR_C = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_VAR_D = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_TEST = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_LOCAL = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_ENG_PTR = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_ENG_MAP = 8'h40;
  localparam logic [ADDR_W-1:0] OFF_PWM = 8'h60;

  // Sizes
  localparam int N_ENG = 3;
  localparam int N_LED = 9;
  localparam int ROWS = 96;
  localparam int ROW_W = 16;
  localparam int MAP_W = 10;
  localparam int GEN_OUT_BIT = 9;
  localparam int LOOP_DEPTH = 4;
  localparam int LK_W = $clog2(LOOP_DEPTH);
  localparam logic [7:0] SEL_GEN_OUT = 8'h10;

  // Instruction word fields
  localparam int IR_BRANCH_BIT = 15;
  localparam int IR_VAR_BIT = 14;
  localparam int LOOP_LSB = 7;
  localparam int OP_LSB = 8;
  localparam int ENG_LSB = 16;

  // Timing
  localparam int CLK_HZ = 40_000_000;
  localparam int ENGINE_HZ = 32_768;
  localparam int EXEC_STEPS = 16;
  localparam int EXEC_CYC = CLK_HZ * EXEC_STEPS / ENGINE_HZ;

  typedef enum logic [3:0] {
    OP_DUTY_LOAD = 4'h0,
    OP_TABLE_BOUNDS_BEGIN = 4'h1,
    OP_TABLE_BOUNDS_FINISH = 4'h2,
    OP_TABLE_BEGIN_ACTIVATE = 4'h3,
    OP_DRIVER_CONNECT = 4'h4,
    OP_RELEASE = 4'h5,
    OP_ACTIVATE_FOLLOWING = 4'h6,
    OP_ACTIVATE_PRECEDING = 4'h7,
    OP_POINTER_FOLLOWING_ROW = 4'h8,
    OP_POINTER_PRECEDING_ROW = 4'h9,
    OP_ACTIVATE_JUMP = 4'ha,
    OP_POINTER_JUMP_ROW = 4'hb
  } op_t;

  typedef enum logic [1:0] {IDLE, EXEC, FETCH, HOLD} phase_t;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  typedef struct packed {
    phase_t st;
    logic [15:0] cnt;
    logic [1:0] eng;
    logic [15:0] ir;
    logic [N_ENG-1:0][6:0] ptr;
    logic [N_ENG-1:0][6:0] beg;
    logic [N_ENG-1:0][6:0] fin;
    logic [N_ENG-1:0][6:0] pc;
    logic [N_ENG-1:0][MAP_W-1:0] map;
    logic [N_ENG-1:0][7:0] duty;
    logic [N_ENG-1:0][LOOP_DEPTH-1:0] lv;
    logic [N_ENG-1:0][LOOP_DEPTH-1:0][6:0] ltag;
    logic [N_ENG-1:0][LOOP_DEPTH-1:0][5:0] lcnt;
    logic [N_ENG-1:0][15:0] loc;
    logic [N_LED-1:0][7:0] level;
    logic [N_LED-1:0][7:0] pwm;
    logic gen_out;
    logic gen_out_sw;
    logic [7:0] var_c;
    logic [7:0] var_d;
    logic d_src;
    logic [6:0] paddr;
    logic aw_v;
    logic [ADDR_W-1:0] awaddr;
    logic w_v;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic b_v;
    logic [1:0] bresp;
    logic r_v;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  localparam state_t STATE_RST = '0;

endpackage : led_map_pkg

// *** design/prog_mem.sv ***
`timescale 1ns/1ps
module prog_mem import led_map_pkg::*; #(
  parameter int DEPTH = ROWS,
  parameter int WIDTH = ROW_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic re,
  input wire logic [6:0] addr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] rdata
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (we && addr < DEPTH) begin
      mem[addr] <= wdata;
    end
    if (!aresetn) begin
      rdata <= '0;
    end else if (re) begin
      rdata <= (addr < DEPTH) ? mem[addr] : '0;
    end
  end
endmodule : prog_mem

// *** design/engine_led_map_and_loop_exec.sv ***
// Register access over AXI4-Lite and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// Function
// [RL1] Engine maps any subset of nine drivers
// [RL2] Mapping rows live in program memory
// [RL3] Bounds instructions record first and last rows
// [RL4] Table begin also activates first row
// [RL5] Connect selects none, one LED, or output
// [RL6] Detached LED follows its own PWM register
// [RL7] Detached output follows serial bus value
// [RL8] Release drops all mappings of engine
// [RL9] Activate following row, wrap to start
// [RL10] Activate preceding row, wrap to end
// [RL11] Activation pushes no duty until duty load
// [RL12] Pointer following row leaves connections alone
// [RL13] Pointer preceding row leaves connections alone
// [RL14] Activate jump loads pointer and applies row
// [RL15] Pointer jump loads pointer only
// [RL16] Branch loads step number into counter
// [RL17] Loop count 0 to 63, 0 forever
// [RL18] Loops nest, each level own count
// [RL19] Branch takes sixteen engine clock cycles
// [RL20] Variable loop count chosen by selector
// [RL21] Engines keep separate pointers and maps
// [RL22] Mapping instructions take sixteen engine cycles
// [RL23] Variable D written by bus or test result
module engine_led_map_and_loop_exec import led_map_pkg::*; #(
  parameter int EXEC_CYCLES = EXEC_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire axi_req_t s_axi_req,
  output axi_rsp_t s_axi_rsp,
  input wire logic [7:0] test_result,
  output logic [N_LED-1:0][7:0] led_duty,
  output logic general_output_pin,
  output logic [N_ENG-1:0][MAP_W-1:0] engine_map,
  output logic [N_ENG-1:0][6:0] engine_pc,
  output logic exec_busy
);
  state_t s_q;
  state_t s_d;
  logic mem_we;
  logic mem_re;
  logic [6:0] mem_addr;
  logic [ROW_W-1:0] mem_wdata;
  logic [ROW_W-1:0] mem_rdata;
  logic [N_LED-1:0] own;
  logic gen_out_own;
  logic [1:0] e;
  logic [6:0] row;
  logic [6:0] step_pc;
  logic act;
  logic push;
  logic [31:0] wd;
  logic [7:0] vsel;
  logic [5:0] loops;
  logic lhit;
  logic lfree;
  logic [LK_W-1:0] hk;
  logic [LK_W-1:0] fk;
  op_t op;
  logic br;

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] v,
                                        input logic [3:0] b);
    merge = o;
    for (int k = 0; k < 4; k++) begin
      if (b[k]) begin
        merge[8*k +: 8] = v[8*k +: 8];
      end
    end
  endfunction : merge

  function automatic logic [6:0] fwd(input logic [6:0] p, input logic [6:0] b,
                                     input logic [6:0] f);
    fwd = (p == f) ? b : p + 7'h01;
  endfunction : fwd

  function automatic logic [6:0] back(input logic [6:0] p, input logic [6:0] b,
                                      input logic [6:0] f);
    back = (p == b) ? f : p - 7'h01;
  endfunction : back

  function automatic logic [MAP_W-1:0] sel_map(input logic [7:0] v);
    sel_map = '0;
    if (v == SEL_GEN_OUT) begin
      sel_map[GEN_OUT_BIT] = 1'b1;
    end else if (v >= 8'h01 && v <= 8'(N_LED)) begin
      sel_map = MAP_W'(1) << (v - 8'h01);
    end
  endfunction : sel_map

  function automatic logic any_map(input logic [N_ENG-1:0][MAP_W-1:0] m, input int b);
    any_map = 1'b0;
    for (int k = 0; k < N_ENG; k++) begin
      any_map = any_map | m[k][b];
    end
  endfunction : any_map

  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (a == OFF_INSTR) || (a == OFF_PROG_ADDR) || (a == OFF_PROG_DATA) ||
              (a == OFF_GEN_OUT) || (a == OFF_VAR_C) || (a == OFF_VAR_D) ||
              (a == OFF_TEST) || (a == OFF_STATUS);
    for (int k = 0; k < N_ENG; k++) begin
      if (a == OFF_LOCAL + ADDR_W'(4*k) || a == OFF_ENG_PTR + ADDR_W'(4*k) ||
          a == OFF_ENG_MAP + ADDR_W'(4*k)) begin
        reg_hit = 1'b1;
      end
    end
    for (int k = 0; k < N_LED; k++) begin
      if (a == OFF_PWM + ADDR_W'(4*k)) begin
        reg_hit = 1'b1;
      end
    end
  endfunction : reg_hit

  function automatic logic [31:0] reg_read(input state_t s, input logic [ADDR_W-1:0] a,
                                           input logic [7:0] t);
    reg_read = '0;
    case (a)
      OFF_INSTR: reg_read = {14'h0, s.eng, s.ir};
      OFF_PROG_ADDR: reg_read = {25'h0, s.paddr};
      OFF_GEN_OUT: reg_read = {31'h0, s.gen_out_sw};
      OFF_VAR_C: reg_read = {24'h0, s.var_c};
      OFF_VAR_D: reg_read = {23'h0, s.d_src, s.var_d};
      OFF_TEST: reg_read = {24'h0, t};
      OFF_STATUS: reg_read = {31'h0, s.st != IDLE};
      default: begin
        for (int k = 0; k < N_ENG; k++) begin
          if (a == OFF_LOCAL + ADDR_W'(4*k)) begin
            reg_read = {16'h0, s.loc[k]};
          end
          if (a == OFF_ENG_PTR + ADDR_W'(4*k)) begin
            reg_read = {1'h0, s.pc[k], 1'h0, s.fin[k], 1'h0, s.beg[k], 1'h0, s.ptr[k]};
          end
          if (a == OFF_ENG_MAP + ADDR_W'(4*k)) begin
            reg_read = {8'h0, s.duty[k], 6'h0, s.map[k]};
          end
        end
        for (int k = 0; k < N_LED; k++) begin
          if (a == OFF_PWM + ADDR_W'(4*k)) begin
            reg_read = {24'h0, s.pwm[k]};
          end
        end
      end
    endcase
  endfunction : reg_read

  // Channel ownership by any engine
  for (genvar i = 0; i < N_LED; i++) begin : g_own
    assign own[i] = any_map(s_q.map, i); // RL1
  end
  assign gen_out_own = any_map(s_q.map, GEN_OUT_BIT);

  assign op = op_t'(s_q.ir[OP_LSB +: 4]);
  assign br = s_q.ir[IR_BRANCH_BIT];

  prog_mem #(
    .DEPTH(ROWS),
    .WIDTH(ROW_W)
  ) u_mem (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(mem_we),
    .re(mem_re),
    .addr(mem_addr),
    .wdata(mem_wdata),
    .rdata(mem_rdata)
  );

  always_comb begin
    s_d = s_q;
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_addr = s_q.paddr;
    mem_wdata = '0;
    e = s_q.eng;
    row = s_q.ptr[e];
    act = 1'b0;
    push = 1'b0;
    wd = merge(reg_read(s_q, s_q.awaddr, test_result), s_q.wdata, s_q.wstrb);
    step_pc = (s_q.pc[e] == 7'(ROWS-1)) ? 7'h00 : s_q.pc[e] + 7'h01;
    lhit = 1'b0;
    lfree = 1'b0;
    hk = '0;
    fk = '0;
    // Bus channels
    if (!s_q.aw_v && s_axi_req.awvalid) begin
      s_d.aw_v = 1'b1;
      s_d.awaddr = s_axi_req.awaddr;
    end
    if (!s_q.w_v && s_axi_req.wvalid) begin
      s_d.w_v = 1'b1;
      s_d.wdata = s_axi_req.wdata;
      s_d.wstrb = s_axi_req.wstrb;
    end
    if (s_q.b_v && s_axi_req.bready) begin
      s_d.b_v = 1'b0;
    end
    if (s_q.r_v && s_axi_req.rready) begin
      s_d.r_v = 1'b0;
    end
    if (!s_q.r_v && s_axi_req.arvalid) begin
      s_d.r_v = 1'b1;
      s_d.rdata = reg_read(s_q, s_axi_req.araddr, test_result);
      s_d.rresp = reg_hit(s_axi_req.araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    // Register writes
    if (s_q.aw_v && s_q.w_v && !s_q.b_v) begin
      s_d.aw_v = 1'b0;
      s_d.w_v = 1'b0;
      s_d.b_v = 1'b1;
      s_d.bresp = reg_hit(s_q.awaddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_q.awaddr)
        OFF_INSTR: begin
          if (s_q.st == IDLE && wd[ENG_LSB +: 2] < 2'(N_ENG)) begin
            s_d.st = EXEC;
            s_d.ir = wd[15:0];
            s_d.eng = wd[ENG_LSB +: 2];
            s_d.cnt = 16'(EXEC_CYCLES - 1);
          end
        end
        OFF_PROG_ADDR: s_d.paddr = (wd[6:0] < 7'(ROWS)) ? wd[6:0] : 7'h00;
        OFF_PROG_DATA: begin
          if (s_q.st == IDLE) begin
            mem_we = 1'b1; // RL2
            mem_wdata = wd[ROW_W-1:0];
            s_d.paddr = (s_q.paddr == 7'(ROWS-1)) ? 7'h00 : s_q.paddr + 7'h01;
          end
        end
        OFF_GEN_OUT: s_d.gen_out_sw = wd[0];
        OFF_VAR_C: s_d.var_c = wd[7:0];
        OFF_VAR_D: begin
          s_d.var_d = wd[7:0]; // RL23
          s_d.d_src = wd[8]; // RL23
        end
        default: begin
          for (int k = 0; k < N_ENG; k++) begin
            if (s_q.awaddr == OFF_LOCAL + ADDR_W'(4*k)) begin
              s_d.loc[k] = wd[15:0];
            end
          end
          for (int k = 0; k < N_LED; k++) begin
            if (s_q.awaddr == OFF_PWM + ADDR_W'(4*k)) begin
              s_d.pwm[k] = wd[7:0];
            end
          end
        end
      endcase
    end
    // Loop count source
    unique case (s_q.ir[LOOP_LSB +: 2])
      2'h0: vsel = s_q.loc[e][7:0]; // RL20
      2'h1: vsel = s_q.loc[e][15:8]; // RL20
      2'h2: vsel = s_q.var_c; // RL20
      2'h3: vsel = s_q.d_src ? test_result : s_q.var_d; // RL20 RL23
    endcase
    loops = s_q.ir[IR_VAR_BIT] ? vsel[5:0] : s_q.ir[LOOP_LSB +: 6]; // RL17
    for (int k = LOOP_DEPTH - 1; k >= 0; k--) begin
      if (s_q.lv[e][k] && s_q.ltag[e][k] == s_q.pc[e]) begin
        lhit = 1'b1; // RL18
        hk = LK_W'(k);
      end
      if (!s_q.lv[e][k]) begin
        lfree = 1'b1;
        fk = LK_W'(k);
      end
    end
    // Instruction sequencer
    unique case (s_q.st)
      IDLE: begin
      end
      EXEC: begin
        s_d.cnt = s_q.cnt - 16'h0001;
        s_d.st = HOLD;
        s_d.pc[e] = step_pc;
        if (br) begin
          if (lhit) begin
            if (s_q.lcnt[e][hk] == 6'h01) begin
              s_d.lv[e][hk] = 1'b0; // RL18
            end else begin
              s_d.lcnt[e][hk] = s_q.lcnt[e][hk] - 6'h01; // RL18
              s_d.pc[e] = s_q.ir[6:0]; // RL16
            end
          end else if (loops == 6'h00) begin
            s_d.pc[e] = s_q.ir[6:0]; // RL16 RL17
          end else if (loops != 6'h01 && lfree) begin
            s_d.lv[e][fk] = 1'b1; // RL18
            s_d.ltag[e][fk] = s_q.pc[e];
            s_d.lcnt[e][fk] = loops - 6'h01; // RL17
            s_d.pc[e] = s_q.ir[6:0]; // RL16
          end
        end else begin
          case (op)
            OP_DUTY_LOAD: begin
              s_d.duty[e] = s_q.ir[7:0];
              push = 1'b1;
            end
            OP_TABLE_BOUNDS_BEGIN: s_d.beg[e] = s_q.ir[6:0]; // RL3 RL21
            OP_TABLE_BOUNDS_FINISH: s_d.fin[e] = s_q.ir[6:0]; // RL3 RL21
            OP_TABLE_BEGIN_ACTIVATE: begin
              s_d.beg[e] = s_q.ir[6:0]; // RL4
              row = s_q.ir[6:0]; // RL4
              act = 1'b1;
            end
            OP_DRIVER_CONNECT: s_d.map[e] = sel_map(s_q.ir[7:0]); // RL5
            OP_RELEASE: s_d.map[e] = '0; // RL8
            OP_ACTIVATE_FOLLOWING: begin
              row = fwd(s_q.ptr[e], s_q.beg[e], s_q.fin[e]); // RL9
              act = 1'b1;
            end
            OP_ACTIVATE_PRECEDING: begin
              row = back(s_q.ptr[e], s_q.beg[e], s_q.fin[e]); // RL10
              act = 1'b1;
            end
            OP_POINTER_FOLLOWING_ROW: row = fwd(s_q.ptr[e], s_q.beg[e], s_q.fin[e]); // RL12
            OP_POINTER_PRECEDING_ROW: row = back(s_q.ptr[e], s_q.beg[e], s_q.fin[e]); // RL13
            OP_ACTIVATE_JUMP: begin
              row = s_q.ir[6:0]; // RL14
              act = 1'b1;
            end
            OP_POINTER_JUMP_ROW: row = s_q.ir[6:0]; // RL15
            default: begin
            end
          endcase
          s_d.ptr[e] = row; // RL21
          if (act) begin
            mem_re = 1'b1; // RL2
            mem_addr = row;
            s_d.st = FETCH;
          end
        end
      end
      FETCH: begin
        s_d.map[e] = mem_rdata[MAP_W-1:0]; // RL1 RL21
        s_d.cnt = s_q.cnt - 16'h0001;
        s_d.st = HOLD;
      end
      HOLD: begin
        if (s_q.cnt == 16'h0000) begin
          s_d.st = IDLE; // RL19 RL22
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
    endcase
    // Output levels
    for (int i = 0; i < N_LED; i++) begin
      if (!own[i]) begin
        s_d.level[i] = s_q.pwm[i]; // RL6
      end else if (push && s_q.map[e][i]) begin
        s_d.level[i] = s_q.ir[7:0]; // RL11
      end
    end
    if (!gen_out_own) begin
      s_d.gen_out = s_q.gen_out_sw; // RL7
    end else if (push && s_q.map[e][GEN_OUT_BIT]) begin
      s_d.gen_out = |s_q.ir[7:0]; // RL11
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_rsp.awready = !s_q.aw_v;
  assign s_axi_rsp.wready = !s_q.w_v;
  assign s_axi_rsp.bvalid = s_q.b_v;
  assign s_axi_rsp.bresp = s_q.bresp;
  assign s_axi_rsp.arready = !s_q.r_v;
  assign s_axi_rsp.rvalid = s_q.r_v;
  assign s_axi_rsp.rdata = s_q.rdata;
  assign s_axi_rsp.rresp = s_q.rresp;
  assign led_duty = s_q.level;
  assign general_output_pin = s_q.gen_out;
  assign engine_map = s_q.map;
  assign engine_pc = s_q.pc;
  assign exec_busy = s_q.st != IDLE;

  // Checks
  logic [15:0] blen;
  logic ex;
  logic [MAP_W-1:0] row_map;
  logic [7:0] pwm0;
  always_ff @(posedge aclk) begin
    if (!aresetn || !exec_busy) begin
      blen <= 16'h0000;
    end else begin
      blen <= blen + 16'h0001;
    end
  end
  assign ex = s_q.st == EXEC && !br;
  assign row_map = mem_rdata[MAP_W-1:0];
  assign pwm0 = s_q.pwm[0];

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  follow_wrap_a: assert property ( // RL9
    ex && op == OP_ACTIVATE_FOLLOWING && s_q.ptr[s_q.eng] == s_q.fin[s_q.eng]
    |=> s_q.ptr[s_q.eng] == $past(s_q.beg[s_q.eng]) ##1 s_q.map[s_q.eng] == $past(row_map)
  ) else $error("following row did not wrap to start");
  precede_wrap_a: assert property ( // RL10
    ex && op == OP_ACTIVATE_PRECEDING && s_q.ptr[s_q.eng] == s_q.beg[s_q.eng]
    |=> s_q.ptr[s_q.eng] == $past(s_q.fin[s_q.eng]) && s_q.st == FETCH
  ) else $error("preceding row did not wrap to end");
  pointer_only_a: assert property ( // RL12 RL13 RL15 RL21
    ex && (op == OP_POINTER_FOLLOWING_ROW || op == OP_POINTER_PRECEDING_ROW ||
           op == OP_POINTER_JUMP_ROW) |=> $stable(s_q.map) && s_q.st == HOLD
  ) else $error("pointer move changed a mapping");
  jump_row_a: assert property ( // RL14
    ex && op == OP_ACTIVATE_JUMP
    |=> s_q.ptr[s_q.eng] == $past(s_q.ir[6:0]) ##1 s_q.map[s_q.eng] == $past(row_map)
  ) else $error("jump row not activated");
  bounds_set_a: assert property ( // RL3 RL4
    ex && (op == OP_TABLE_BOUNDS_BEGIN || op == OP_TABLE_BEGIN_ACTIVATE)
    |=> s_q.beg[s_q.eng] == $past(s_q.ir[6:0])
  ) else $error("table start not recorded");
  connect_one_a: assert property ( // RL5
    ex && op == OP_DRIVER_CONNECT
    |=> $onehot0(s_q.map[s_q.eng]) && s_q.map[s_q.eng] == sel_map($past(s_q.ir[7:0]))
  ) else $error("connect did not select one output");
  release_all_a: assert property ( // RL8
    ex && op == OP_RELEASE |=> s_q.map[s_q.eng] == '0
  ) else $error("release left a mapping");
  branch_load_a: assert property ( // RL16 RL17
    s_q.st == EXEC && br && !s_q.ir[IR_VAR_BIT] && s_q.ir[LOOP_LSB +: 6] == 6'h00
    |=> s_q.pc[s_q.eng] == $past(s_q.ir[6:0])
  ) else $error("endless branch did not load step");
  exec_len_a: assert property ( // RL19 RL22
    $fell(exec_busy) |-> blen == 16'(EXEC_CYCLES)
  ) else $error("instruction length wrong");
  detach_led_a: assert property ( // RL6
    !own[0] |=> led_duty[0] == $past(pwm0)
  ) else $error("detached LED ignores its PWM register");
  pin_serial_a: assert property ( // RL7
    !gen_out_own |=> general_output_pin == $past(s_q.gen_out_sw)
  ) else $error("detached output ignores bus value");
  hold_duty_a: assert property ( // RL11
    s_q.st == FETCH && own[0] |=> $stable(led_duty[0])
  ) else $error("activation pushed a duty value");

  wrap_seen_c: cover property (ex && op == OP_ACTIVATE_FOLLOWING &&
                               s_q.ptr[s_q.eng] == s_q.fin[s_q.eng]);
  loop_hit_c: cover property (s_q.st == EXEC && br && lhit);
  duty_push_c: cover property (push && |(s_q.map[s_q.eng]));
endmodule : engine_led_map_and_loop_exec

// *** verif/led_out_model.sv ***
`timescale 1ns/1ps
module led_out_model import led_map_pkg::*; (
  input wire logic aclk,
  input wire logic [N_LED-1:0][7:0] led_duty,
  input wire logic general_output_pin,
  output logic [N_LED-1:0][7:0] duty_seen,
  output logic pin_seen
);
  // Channels and output pin take the level driven to them
  always_ff @(posedge aclk) begin
    duty_seen <= led_duty;
    pin_seen <= general_output_pin;
  end
endmodule : led_out_model

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top import led_map_pkg::*;;
  localparam int EC = 8;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  axi_req_t req = '0;
  axi_rsp_t rsp;
  logic [7:0] test_result = 8'h00;
  logic [N_LED-1:0][7:0] led_duty;
  logic [N_LED-1:0][7:0] duty_seen;
  logic general_output_pin;
  logic pin_seen;
  logic [N_ENG-1:0][MAP_W-1:0] engine_map;
  logic [N_ENG-1:0][6:0] engine_pc;
  logic exec_busy;
  int num_errors = 0;
  int total_checks = 0;

  always #12.5 aclk = ~aclk;

  engine_led_map_and_loop_exec #(.EXEC_CYCLES(EC)) dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_req(req), .s_axi_rsp(rsp), .test_result(test_result), .led_duty(led_duty),
    .general_output_pin(general_output_pin), .engine_map(engine_map), .engine_pc(engine_pc),
    .exec_busy(exec_busy));

  led_out_model model (.aclk(aclk), .led_duty(led_duty),
    .general_output_pin(general_output_pin),
    .duty_seen(duty_seen), .pin_seen(pin_seen));

  task results;
    if (num_errors == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : results

  task chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      num_errors++;
      $display("mismatch %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    r = 2'h3;
    for (n = 0; n < 60 && r === 2'h3; n++) begin
      @(posedge aclk);
      if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1) begin
        r = rsp.bresp;
        req.bready <= 1'b0;
      end
    end
    if (n >= 60) num_errors++;
  endtask : wr

  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    r = 2'h3;
    for (n = 0; n < 60 && r === 2'h3; n++) begin
      @(posedge aclk);
      if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1) begin
        r = rsp.rresp;
        d = rsp.rdata;
        req.rready <= 1'b0;
      end
    end
    if (n >= 60) num_errors++;
  endtask : rd

  task ins(input logic [1:0] eng, input logic [15:0] w);
    logic [1:0] r;
    int n;
    n = 0;
    wr(OFF_INSTR, {14'h0000, eng, w}, r);
    repeat (EC + 4) begin
      @(posedge aclk);
      if (exec_busy === 1'b1) n++;
    end
    // First busy edge falls in the response cycle
    chk(n, EC - 1);
  endtask : ins

  task t_reset;
    logic [31:0] d;
    logic [1:0] r;
    chk(engine_map, '0);
    chk(engine_pc, '0);
    rd(8'hf0, d, r);
    chk(r, RESP_SLVERR);
    chk(d, 32'h0000_0000);
  endtask : t_reset

  task t_table;
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] w[8] = '{16'h0600, 16'h0600, 16'h0600, 16'h0700, 16'h0800, 16'h0b0b,
      16'h0900, 16'h0a0b};
    logic [6:0] ep[8] = '{7'd11, 7'd12, 7'd10, 7'd12, 7'd10, 7'd11, 7'd10, 7'd11};
    logic [9:0] em[8] = '{10'h002, 10'h200, 10'h001, 10'h200, 10'h200, 10'h200, 10'h200,
      10'h002};
    wr(OFF_PROG_ADDR, 32'h0000_000a, r);
    wr(OFF_PROG_DATA, 32'h0000_0001, r);
    wr(OFF_PROG_DATA, 32'h0000_0002, r);
    wr(OFF_PROG_DATA, 32'h0000_0200, r);
    ins(2'd0, 16'h010a);
    ins(2'd0, 16'h020c);
    ins(2'd0, 16'h030a);
    chk(engine_map[0], 10'h001);
    rd(OFF_ENG_PTR, d, r);
    chk(d, 32'h030c_0a0a);
    for (int i = 0; i < 8; i++) begin
      ins(2'd0, w[i]);
      rd(OFF_ENG_PTR, d, r);
      chk(d[6:0], ep[i]);
      chk(engine_map[0], em[i]);
    end
  endtask : t_table

  task t_connect;
    logic [9:0] e;
    for (int s = 0; s < 18; s++) begin
      ins(2'd1, {8'h04, 8'(s)});
      e = (s == 16) ? 10'h200 : (s >= 1 && s <= 9) ? 10'(1 << (s - 1)) : 10'h000;
      chk(engine_map[1], e);
      chk(engine_map[0], 10'h002);
    end
    ins(2'd1, 16'h0401);
    ins(2'd1, 16'h0500);
    chk(engine_map[1], 10'h000);
  endtask : t_connect

  task t_duty;
    logic [1:0] r;
    wr(OFF_PWM, 32'h0000_0033, r);
    wr(OFF_GEN_OUT, 32'h0000_0000, r);
    ins(2'd1, 16'h0401);
    chk(duty_seen[0], 8'h33);
    ins(2'd1, 16'h0080);
    chk(duty_seen[0], 8'h80);
    ins(2'd1, 16'h0410);
    chk(duty_seen[0], 8'h33);
    ins(2'd1, 16'h0001);
    chk(pin_seen, 1'b1);
    ins(2'd1, 16'h0500);
    chk(pin_seen, 1'b0);
  endtask : t_duty

  task t_branch;
    logic [1:0] r;
    logic [6:0] nest[6] = '{7'd6, 7'd7, 7'd6, 7'd6, 7'd7, 7'd8};
    logic [31:0] d;
    ins(2'd2, 16'h8005);
    chk(engine_pc[2], 7'd5);
    ins(2'd2, 16'h8005);
    chk(engine_pc[2], 7'd5);
    for (int i = 0; i < 3; i++) begin
      ins(2'd2, 16'h8185);
      chk(engine_pc[2], (i == 2) ? 7'd6 : 7'd5);
    end
    for (int i = 0; i < 6; i++) begin
      ins(2'd2, 16'h8106);
      chk(engine_pc[2], nest[i]);
    end
    wr(OFF_LOCAL + 8'h08, 32'h0000_0202, r);
    wr(OFF_VAR_C, 32'h0000_0002, r);
    wr(OFF_VAR_D, 32'h0000_0100, r);
    rd(OFF_VAR_D, d, r);
    chk(d, 32'h0000_0100);
    test_result <= 8'h02;
    for (int s = 0; s < 4; s++) begin
      ins(2'd2, 16'hc000 | 16'(s << 7) | 16'(8 + s));
      chk(engine_pc[2], 7'(8 + s));
      ins(2'd2, 16'hc000 | 16'(s << 7) | 16'(8 + s));
      chk(engine_pc[2], 7'(9 + s));
    end
    wr(OFF_VAR_D, 32'h0000_0002, r);
    test_result <= 8'h05;
    ins(2'd2, 16'hc18c);
    chk(engine_pc[2], 7'd12);
    ins(2'd2, 16'hc18c);
    chk(engine_pc[2], 7'd13);
  endtask : t_branch

  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_table();
    t_connect();
    t_duty();
    t_branch();
    results();
  end

  initial begin
    #500_000;
    num_errors++;
    results();
  end
endmodule : tb_top
